// *** design/tcp_bank.sv ***
// calibration and phase configuration bank for rail 1 telemetry and phase split
// assumes the serial front end delivers decoded page-0 command reads and writes, synchronous to CLK_SYS
//
// Overview of operation
// - reserved bits 15:14 of voltage cal and bit 7 of phase cfg read zero.
// - voltage offset bits 13:8, six-bit two's complement, step 6.25 mV over divider ratio.
// - processor voltage value is 504 minus the sum of scaled sense voltage and signed offset.
// - readback value is sense voltage times 1023/1.6, times gain/256, plus offset.
// - voltage calibration touches only rail 1 reporting, never regulation or rail 2.
// - current offset bits 15:9, seven-bit two's complement, -64..63, added to code.
// - current code is 1.279 times sensed quantity over nine-bit gain, plus offset.
// - current calibration applies only to processor current telemetry.
// - current code full scale is 0xff at the maximum reportable current.
// - both calibration registers are page 0 commands holding rail 1 gain and offset.
// - assignment bits 6:4 select 3+2, 2+2, 3+1, 2+1, 1+1 or 4+1.
// - force bit 3 makes bits 2:0 set rail 1 power state; otherwise ignored.
// - forced codes: 000 one DCM, 010 two, 011 three, 100 four, others one CCM.
// - in 4+1, PWM 1-4 belong to rail 1 and PWM 5 to rail 2.
module tcp_bank
  import tcp_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  input  wire logic [7:0]  CMD_PAGE,
  input  wire logic [7:0]  CMD_CODE,
  input  wire logic        CMD_WR,
  input  wire logic [15:0] CMD_WDATA,
  input  wire logic        CMD_RD,
  output logic      [15:0] CMD_RDATA,
  output logic             CMD_RVALID,
  input  wire logic [9:0]  SENSE_VDIFF_CODE,
  input  wire logic [15:0] SENSE_IOUT,
  input  wire logic [2:0]  NORM_PHASES,
  input  wire logic        NORM_DCM,
  output logic      [9:0]  VOUT_SVI_CODE,
  output logic      [15:0] VOUT_READBACK,
  output logic      [7:0]  IOUT_SVI_CODE,
  output logic      [4:0]  PWM_RAIL1_SEL,
  output logic      [4:0]  PWM_RAIL2_SEL,
  output logic      [2:0]  RAIL1_ASSIGNED,
  output logic      [2:0]  RAIL2_ASSIGNED,
  output logic      [2:0]  RAIL1_ACTIVE,
  output logic             RAIL1_DCM,
  output logic             RAIL1_FORCED
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // clamp a signed value into 0..hi
  function automatic logic [15:0] sat(input logic signed [31:0] v, input int hi);
    logic [15:0] r;
    r = 16'h0000;
    if (v < 0) begin
      r = 16'h0000;
    end else if (v > hi) begin
      r = hi[15:0];
    end else begin
      r = v[15:0];
    end
    return r;
  endfunction : sat

  function automatic tcp_asg_s decode_asg(input logic [2:0] code);
    tcp_asg_s a;
    a = '{rail1_phases: 3'd3, rail2_phases: 3'd2, rail1_pwm: 5'b00111, rail2_pwm: 5'b11000};
    unique case (code)
      ASG_2P2: a = '{rail1_phases: 3'd2, rail2_phases: 3'd2, rail1_pwm: 5'b00011, rail2_pwm: 5'b01100};
      ASG_3P1: a = '{rail1_phases: 3'd3, rail2_phases: 3'd1, rail1_pwm: 5'b00111, rail2_pwm: 5'b01000};
      ASG_2P1: a = '{rail1_phases: 3'd2, rail2_phases: 3'd1, rail1_pwm: 5'b00011, rail2_pwm: 5'b00100};
      ASG_1P1: a = '{rail1_phases: 3'd1, rail2_phases: 3'd1, rail1_pwm: 5'b00001, rail2_pwm: 5'b00010};
      ASG_4P1: a = '{rail1_phases: 3'd4, rail2_phases: 3'd1, rail1_pwm: 5'b01111, rail2_pwm: 5'b10000};
      default: a = '{rail1_phases: 3'd3, rail2_phases: 3'd2, rail1_pwm: 5'b00111, rail2_pwm: 5'b11000};
    endcase
    return a;
  endfunction : decode_asg

  //////////////////////////////////////////////////////////////////////////////
  // state

  tcp_state_s s_r;
  tcp_state_s s_nxt;

  logic               wr_hit;
  logic [15:0]        rd_mux;
  logic [17:0]        vprod;
  logic signed [31:0] vscaled;
  logic signed [31:0] vofs;
  logic [26:0]        inum;
  logic [18:0]        iden;
  logic [26:0]        iquot;
  logic signed [31:0] iofs;
  logic [15:0]        vsvi_full;
  logic [15:0]        icode_full;
  logic [2:0]         fps;
  logic [2:0]         req_ph;
  logic               req_dcm;
  tcp_asg_s           asg;

  always_comb begin
    s_nxt  = s_r;
    wr_hit = CMD_WR && (CMD_PAGE == PAGE_RAIL1);

    if (wr_hit && CMD_CODE == CMD_VOUT_CAL) begin
      s_nxt.vout_cal_r = CMD_WDATA & VOUT_CAL_MASK;
    end
    if (wr_hit && CMD_CODE == CMD_IOUT_CAL) begin
      s_nxt.iout_cal_r = CMD_WDATA & IOUT_CAL_MASK;
    end
    if (wr_hit && CMD_CODE == CMD_PHASE_CFG) begin
      s_nxt.phase_cfg_r = CMD_WDATA[7:0] & PHASE_CFG_MASK;
    end

    // reads see the stored, already masked value
    rd_mux = 16'h0000;
    if (CMD_PAGE == PAGE_RAIL1) begin
      unique case (CMD_CODE)
        CMD_VOUT_CAL:  rd_mux = s_r.vout_cal_r;
        CMD_IOUT_CAL:  rd_mux = s_r.iout_cal_r;
        CMD_PHASE_CFG: rd_mux = {8'h00, s_r.phase_cfg_r};
        default:       rd_mux = 16'h0000;
      endcase
    end
    s_nxt.rd_valid_r = CMD_RD;
    if (CMD_RD) begin
      s_nxt.rd_data_r = rd_mux;
    end

    // voltage: sense code already carries the 1023/1.6 scaling
    vprod   = {8'h00, SENSE_VDIFF_CODE} * {10'h000, s_r.vout_cal_r[VGAIN_LSB +: VGAIN_W]};
    vscaled = 32'(vprod >> VGAIN_SHIFT);
    vofs    = 32'(signed'(s_r.vout_cal_r[VOFS_LSB +: VOFS_W]));
    s_nxt.vout_read_r = sat(vscaled + vofs, 32'hffff);
    // clamp at full width first, then keep the code field
    vsvi_full         = sat(VSVI_BASE - (vscaled + vofs), VREPORT_MAX);
    s_nxt.vout_svi_r  = vsvi_full[9:0];

    // current: 1.279 as 1279/1000; zero gain pins the quotient at full scale before the offset is added
    inum  = 27'(SENSE_IOUT * ISCALE_NUM);
    iden  = 19'(ISCALE_DEN * s_r.iout_cal_r[IGAIN_LSB +: IGAIN_W]);
    iquot = (iden == 19'd0) ? 27'(IOUT_CODE_MAX) : inum / 27'(iden);
    iofs  = 32'(signed'(s_r.iout_cal_r[IOFS_LSB +: IOFS_W]));
    icode_full        = sat(32'(iquot) + iofs, int'(IOUT_CODE_MAX));
    s_nxt.iout_code_r = icode_full[7:0];

    // phase split and rail 1 power state
    asg     = decode_asg(s_r.phase_cfg_r[ASSIGN_LSB +: 3]);
    fps     = s_r.phase_cfg_r[FPS_LSB +: 3];
    req_ph  = NORM_PHASES;
    req_dcm = NORM_DCM;
    if (s_r.phase_cfg_r[FORCE_BIT]) begin
      unique case (fps)
        FPS_1PH_DCM: begin
          req_ph  = 3'd1;
          req_dcm = 1'b1;
        end
        FPS_2PH: begin
          req_ph  = 3'd2;
          req_dcm = 1'b0;
        end
        FPS_3PH: begin
          req_ph  = 3'd3;
          req_dcm = 1'b0;
        end
        FPS_4PH: begin
          req_ph  = 3'd4;
          req_dcm = 1'b0;
        end
        default: begin
          req_ph  = 3'd1;
          req_dcm = 1'b0;
        end
      endcase
    end
    s_nxt.asg_r       = asg;
    s_nxt.r1_active_r = (req_ph > asg.rail1_phases) ? asg.rail1_phases : req_ph;
    s_nxt.r1_dcm_r    = req_dcm;
    s_nxt.r1_forced_r = s_r.phase_cfg_r[FORCE_BIT];
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      s_r             <= '0;
      s_r.vout_cal_r  <= VOUT_CAL_RST;
      s_r.iout_cal_r  <= IOUT_CAL_RST;
      s_r.phase_cfg_r <= PHASE_CFG_RST;
      s_r.asg_r       <= '{rail1_phases: 3'd3, rail2_phases: 3'd2, rail1_pwm: 5'b00111, rail2_pwm: 5'b11000};
      s_r.r1_active_r <= 3'd1;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign CMD_RDATA      = s_r.rd_data_r;
  assign CMD_RVALID     = s_r.rd_valid_r;
  assign VOUT_SVI_CODE  = s_r.vout_svi_r;
  assign VOUT_READBACK  = s_r.vout_read_r;
  assign IOUT_SVI_CODE  = s_r.iout_code_r;
  assign PWM_RAIL1_SEL  = s_r.asg_r.rail1_pwm;
  assign PWM_RAIL2_SEL  = s_r.asg_r.rail2_pwm;
  assign RAIL1_ASSIGNED = s_r.asg_r.rail1_phases;
  assign RAIL2_ASSIGNED = s_r.asg_r.rail2_phases;
  assign RAIL1_ACTIVE   = s_r.r1_active_r;
  assign RAIL1_DCM      = s_r.r1_dcm_r;
  assign RAIL1_FORCED   = s_r.r1_forced_r;

endmodule : tcp_bank

// *** shared/tcp_pkg.sv ***
// constants and carrier types for the telemetry calibration and phase configuration bank
// assumes a single system clock and a page-0 command port in front of the bank
package tcp_pkg;

  // command codes on page 0
  localparam logic [7:0]  CMD_VOUT_CAL      = 8'hac;
  localparam logic [7:0]  CMD_IOUT_CAL      = 8'had;
  localparam logic [7:0]  CMD_PHASE_CFG     = 8'hc0;
  localparam logic [7:0]  PAGE_RAIL1        = 8'h00;

  // writable masks; reserved bits are dropped on write and read as zero
  localparam logic [15:0] VOUT_CAL_MASK     = 16'h3fff;
  localparam logic [15:0] IOUT_CAL_MASK     = 16'hffff;
  localparam logic [7:0]  PHASE_CFG_MASK    = 8'h7f;

  // reset values
  localparam logic [15:0] VOUT_CAL_RST      = 16'h0040;
  localparam logic [15:0] IOUT_CAL_RST      = 16'h0001;
  localparam logic [7:0]  PHASE_CFG_RST     = 8'h00;

  // field positions
  localparam int VGAIN_LSB  = 0;
  localparam int VGAIN_W    = 8;
  localparam int VOFS_LSB   = 8;
  localparam int VOFS_W     = 6;
  localparam int IGAIN_LSB  = 0;
  localparam int IGAIN_W    = 9;
  localparam int IOFS_LSB   = 9;
  localparam int IOFS_W     = 7;
  localparam int FPS_LSB    = 0;
  localparam int FORCE_BIT  = 3;
  localparam int ASSIGN_LSB = 4;

  // telemetry arithmetic
  localparam int          VSVI_BASE         = 504;
  localparam int          VGAIN_SHIFT       = 8;
  localparam logic [10:0] ISCALE_NUM        = 11'd1279;
  localparam logic [9:0]  ISCALE_DEN        = 10'd1000;
  localparam logic [7:0]  IOUT_CODE_MAX     = 8'hff;
  localparam int          VREPORT_MAX       = 1023;

  // phase assignment codes
  localparam logic [2:0]  ASG_3P2 = 3'b000;
  localparam logic [2:0]  ASG_2P2 = 3'b001;
  localparam logic [2:0]  ASG_3P1 = 3'b010;
  localparam logic [2:0]  ASG_2P1 = 3'b011;
  localparam logic [2:0]  ASG_1P1 = 3'b100;
  localparam logic [2:0]  ASG_4P1 = 3'b111;

  // forced power state codes
  localparam logic [2:0]  FPS_1PH_DCM = 3'b000;
  localparam logic [2:0]  FPS_2PH     = 3'b010;
  localparam logic [2:0]  FPS_3PH     = 3'b011;
  localparam logic [2:0]  FPS_4PH     = 3'b100;

  typedef struct packed {
    logic [2:0] rail1_phases;
    logic [2:0] rail2_phases;
    logic [4:0] rail1_pwm;
    logic [4:0] rail2_pwm;
  } tcp_asg_s;

  typedef struct packed {
    logic [15:0] vout_cal_r;
    logic [15:0] iout_cal_r;
    logic [7:0]  phase_cfg_r;
    logic [15:0] rd_data_r;
    logic        rd_valid_r;
    logic [9:0]  vout_svi_r;
    logic [15:0] vout_read_r;
    logic [7:0]  iout_code_r;
    tcp_asg_s    asg_r;
    logic [2:0]  r1_active_r;
    logic        r1_dcm_r;
    logic        r1_forced_r;
  } tcp_state_s;

endpackage : tcp_pkg

// *** verification/tcp_bank_sim_tb.sv ***
// self-checking bench for tcp_bank: registers, telemetry and phase split
// assumes tcp_pkg, the checker and the processor model compile first
module tcp_bank_tb
  import tcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rstn = 0, wr = 0, rd = 0, rvalid, ndcm = 0, dcm, frc;
  logic [7:0] cpage = 0, ccode = 0, isvi, iseen;
  logic [15:0] wdata = 0, rdata, vrb, io = 0, mv = VOUT_CAL_RST, mi = IOUT_CAL_RST, mp = 16'(PHASE_CFG_RST);
  logic [9:0] vd = 0, vsvi, vseen;
  logic [4:0] p1, p2;
  logic [2:0] nph = 3'h1, a1, a2, act;
  logic [31:0] r;
  int error_cnt = 0, check_count = 0, cyc = 0, seed = 32'hbf62;
  int t1[8] = '{3, 2, 3, 2, 1, 3, 3, 4};
  int t2[8] = '{2, 2, 1, 1, 1, 2, 2, 1};
  tcp_bank uut (.CLK_SYS(clk_sys), .RSTN(rstn), .CMD_PAGE(cpage), .CMD_CODE(ccode), .CMD_WR(wr),
    .CMD_WDATA(wdata), .CMD_RD(rd), .CMD_RDATA(rdata), .CMD_RVALID(rvalid), .SENSE_VDIFF_CODE(vd),
    .SENSE_IOUT(io), .NORM_PHASES(nph), .NORM_DCM(ndcm), .VOUT_SVI_CODE(vsvi), .VOUT_READBACK(vrb),
    .IOUT_SVI_CODE(isvi), .PWM_RAIL1_SEL(p1), .PWM_RAIL2_SEL(p2), .RAIL1_ASSIGNED(a1),
    .RAIL2_ASSIGNED(a2), .RAIL1_ACTIVE(act), .RAIL1_DCM(dcm), .RAIL1_FORCED(frc));
  tcp_proc_model u_proc (.clk(clk_sys), .vout_code(vsvi), .iout_code(isvi), .vout_seen(vseen),
    .iout_seen(iseen));
  //////////////////////////////////////////////////////////////////
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // strobes stay up between calls so back-to-back commands never re-assign them in one step
  task automatic cmd(bit w, logic [7:0] pg, logic [7:0] cd, logic [15:0] d);
    wr = w;
    rd = !w;
    cpage = pg;
    ccode = cd;
    wdata = d;
    tick(1);
    if (w && pg == 8'h00 && cd == CMD_VOUT_CAL) mv = d & 16'h3fff;
    if (w && pg == 8'h00 && cd == CMD_IOUT_CAL) mi = d;
    if (w && pg == 8'h00 && cd == CMD_PHASE_CFG) mp = d & 16'h007f;
    if (!w) chk(16'(rvalid), 16'h0001);
    if (!w) chk(rdata, pg != 8'h00 ? 16'h0 : cd == CMD_VOUT_CAL ? mv : cd == CMD_IOUT_CAL ? mi :
      cd == CMD_PHASE_CFG ? mp : 16'h0);
  endtask : cmd
  task automatic tel();
    int x, o, i, g, r1, r2, fp;
    o = $signed(mv[13:8]);
    x = ((int'(vd) * int'(mv[7:0])) >>> 8) + o;
    chk(vrb, x < 0 ? 0 : x);
    chk(16'(vseen), 504 - x < 0 ? 0 : (504 - x > 1023 ? 1023 : 504 - x));
    g = int'(mi[8:0]);
    o = $signed(mi[15:9]);
    i = (g == 0 ? 255 : 1279 * int'(io) / (1000 * g)) + o;
    chk(16'(iseen), i < 0 ? 0 : (i > 255 ? 255 : i));
    r1 = t1[mp[6:4]];
    r2 = t2[mp[6:4]];
    chk(16'(a1), r1);
    chk(16'(a2), r2);
    chk(16'(p1), (1 << r1) - 1);
    chk(16'(p2), ((1 << r2) - 1) << r1);
    fp = !mp[3] ? int'(nph) : mp[2:0] == 3'h2 ? 2 : mp[2:0] == 3'h3 ? 3 : mp[2:0] == 3'h4 ? 4 : 1;
    chk(16'(act), fp > r1 ? r1 : fp);
    chk(16'(dcm), mp[3] ? mp[2:0] == 3'h0 : ndcm);
    chk(16'(frc), 16'(mp[3]));
  endtask : tel
  task automatic results();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end
  //////////////////////////////////////////////////////////////////
  initial begin
    tick(6);
    rstn = 1;
    cmd(0, 8'h00, CMD_VOUT_CAL, 16'h0);
    cmd(0, 8'h00, CMD_IOUT_CAL, 16'h0);
    cmd(1, 8'h01, CMD_VOUT_CAL, 16'hffff);
    cmd(0, 8'h01, CMD_VOUT_CAL, 16'h0);
    cmd(1, 8'h00, 8'hae, 16'hffff);
    cmd(0, 8'h00, 8'hae, 16'h0);
    cmd(0, 8'h00, CMD_VOUT_CAL, 16'h0);
    for (int k = 0; k < 64; k++) begin
      r = $random(seed);
      cmd(1, 8'h00, CMD_VOUT_CAL, k[0] ? r[15:0] : {r[15:8], 8'h40});
      cmd(1, 8'h00, CMD_IOUT_CAL, r[31:16]);
      r = $random(seed);
      cmd(1, 8'h00, CMD_PHASE_CFG, {r[15:7], k[2:0], r[0], k[5:3]});
      wr = 0;
      vd = r[25:16];
      io = 16'($random(seed));
      nph = 3'(r[30:29]) + 3'h1;
      ndcm = r[31];
      tick(4);
      tel();
      cmd(0, 8'h00, CMD_VOUT_CAL, 16'h0);
      cmd(0, 8'h00, CMD_IOUT_CAL, 16'h0);
      cmd(0, 8'h00, CMD_PHASE_CFG, 16'h0);
    end
    // mid-run reset must bring back the reset values of all three registers
    rstn = 0;
    rd = 0;
    tick(2);
    rstn = 1;
    mv = VOUT_CAL_RST;
    mi = IOUT_CAL_RST;
    mp = 16'(PHASE_CFG_RST);
    cmd(0, 8'h00, CMD_VOUT_CAL, 16'h0);
    cmd(0, 8'h00, CMD_IOUT_CAL, 16'h0);
    cmd(0, 8'h00, CMD_PHASE_CFG, 16'h0);
    rd = 0;
    tick(3);
    tel();
    results();
  end
endmodule : tcp_bank_tb

// *** verification/tcp_bank_sva.sv ***
// assertions on the command port, telemetry and phase split of tcp_bank
// assumes it is bound into every tcp_bank and sees only its ports
module tcp_bank_sva
  import tcp_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic [7:0]  CMD_PAGE,
  input wire logic [7:0]  CMD_CODE,
  input wire logic        CMD_WR,
  input wire logic [15:0] CMD_WDATA,
  input wire logic        CMD_RD,
  input wire logic [15:0] CMD_RDATA,
  input wire logic        CMD_RVALID,
  input wire logic [9:0]  VOUT_SVI_CODE,
  input wire logic [15:0] VOUT_READBACK,
  input wire logic [4:0]  PWM_RAIL1_SEL,
  input wire logic [4:0]  PWM_RAIL2_SEL,
  input wire logic [2:0]  RAIL1_ASSIGNED,
  input wire logic [2:0]  RAIL1_ACTIVE,
  input wire logic        RAIL1_FORCED
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  sequence s_cfg_wr;
    CMD_WR && CMD_PAGE == PAGE_RAIL1 && CMD_CODE == CMD_PHASE_CFG;
  endsequence
  a_rd_answer: assert property (CMD_RD |=> CMD_RVALID)
    else $error("read not answered");
  a_no_stray: assert property (!CMD_RD |=> !CMD_RVALID)
    else $error("stray read valid");
  a_vcal_rsvd: assert property (CMD_RD && CMD_CODE == CMD_VOUT_CAL |=> CMD_RDATA[15:14] == 2'h0)
    else $error("voltage cal reserved bits set");
  a_phase_rsvd: assert property (CMD_RD && CMD_CODE == CMD_PHASE_CFG |=> CMD_RDATA[15:7] == 9'h000)
    else $error("phase cfg reserved bits set");
  a_vout_pair: assert property (VOUT_READBACK != 16'h0000 && VOUT_READBACK <= 16'd504
    |-> VOUT_SVI_CODE == 10'(16'd504 - VOUT_READBACK))
    else $error("voltage code not 504 minus readback");
  a_force_bit: assert property (s_cfg_wr |-> ##2 RAIL1_FORCED == $past(CMD_WDATA[3], 2))
    else $error("force flag does not follow write");
  a_active_cap: assert property (RAIL1_ACTIVE != 3'h0 && RAIL1_ACTIVE <= RAIL1_ASSIGNED)
    else $error("active phases beyond assignment");
  a_pwm_split: assert property ((PWM_RAIL1_SEL & PWM_RAIL2_SEL) == 5'h00
    && $countones(PWM_RAIL1_SEL) == RAIL1_ASSIGNED)
    else $error("pwm split inconsistent");
  a_four_one: assert property (RAIL1_ASSIGNED == 3'h4 |-> PWM_RAIL1_SEL == 5'h0f && PWM_RAIL2_SEL == 5'h10)
    else $error("four plus one mapping wrong");
endmodule : tcp_bank_sva

bind tcp_bank tcp_bank_sva u_sva (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CMD_PAGE(CMD_PAGE), .CMD_CODE(CMD_CODE),
  .CMD_WR(CMD_WR), .CMD_WDATA(CMD_WDATA), .CMD_RD(CMD_RD), .CMD_RDATA(CMD_RDATA), .CMD_RVALID(CMD_RVALID),
  .VOUT_SVI_CODE(VOUT_SVI_CODE), .VOUT_READBACK(VOUT_READBACK), .PWM_RAIL1_SEL(PWM_RAIL1_SEL),
  .PWM_RAIL2_SEL(PWM_RAIL2_SEL), .RAIL1_ASSIGNED(RAIL1_ASSIGNED), .RAIL1_ACTIVE(RAIL1_ACTIVE),
  .RAIL1_FORCED(RAIL1_FORCED));

// *** verification/tcp_proc_model.sv ***
// processor side of the telemetry link: latches what rail 1 reports each cycle
// assumes the bank's clock; the link itself is a parallel code here
module tcp_proc_model (
  input wire logic       clk,
  input wire logic [9:0] vout_code,
  input wire logic [7:0] iout_code,
  output logic     [9:0] vout_seen,
  output logic     [7:0] iout_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) begin
    vout_seen <= vout_code;
    iout_seen <= iout_code;
  end
endmodule : tcp_proc_model
